// ==== sgs_supervisor.sv ====
/*
  Satellite sync supervisor top: APB registers, hold-off control of the
  sync relay and lamp, test and suppression options, cable delay
  compensation of the time pulse, elevation mask and parameter store.
  Assumes a 50 MHz pclk, an asynchronous pin for satellite tracking and
  satellite elevation reports from receiver logic on the same clock.
*/
//
// Contract
// - Release relay after full hold-off without satellites.
// - Any tracked satellite restarts the hold-off.
// - Hold-off resets to sixty seconds.
// - Hold-off accepts up to 42.5 minutes.
// - Test mode: outputs synced, relay always on.
// - Suppress indications: outputs synced, relay true; the code leaves relay and lamp following sync.
// - Suppress outputs: stop outputs when out of sync.
// - Cable delay in ns compensates output timing.
// - Mask satellites below angle; default five, 0-90.
// - Settings kept in a non-volatile store.
// - Relay energised on lock; lamp mirrors relay.
// - Hold-off counter holds up to 2550 seconds.
`timescale 1ns/1ps
`default_nettype none
module sgs_supervisor
#(
  parameter int TICK_CYCLES = sgs_pkg::TICK_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sat_tracked,
  input  wire logic        sat_in_valid,
  input  wire logic [6:0]  sat_in_elev,
  output var  logic        sat_use_valid,
  output var  logic        sat_use,
  output var  logic        sync_relay,
  output var  logic        lock_indicator_lamp,
  output var  logic        time_valid,
  output var  logic        time_out_en,
  output var  logic        time_pulse,
  output var  logic        irq
);
  localparam int CW = $clog2(TICK_CYCLES);
  localparam int HW = sgs_pkg::HOLD_W;
  localparam int MW = sgs_pkg::MASK_W;

  initial
  begin
    if (TICK_CYCLES < 4096)
      $error("sgs_supervisor: TICK_CYCLES too small for the cable delay.");
  end

  // Clamps a written value to its documented maximum.
  function automatic logic [31:0] fn_clamp(input logic [31:0] v,
                                           input logic [31:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  // Register state.
  logic [sgs_pkg::CTRL_W-1:0]  ctrl;
  logic [sgs_pkg::HOLD_W-1:0]  hold_time;
  logic [sgs_pkg::DELAY_W-1:0] cable_delay;
  logic [sgs_pkg::MASK_W-1:0]  mask_angle;
  logic [sgs_pkg::IRQ_W-1:0]   irq_stat;
  logic [sgs_pkg::IRQ_W-1:0]   irq_mask;
  logic                        trk_meta;
  logic                        trk;
  logic [CW-1:0]               sec_cnt;
  logic                        in_sync;
  logic                        in_sync_d;
  logic [sgs_pkg::HOLD_W-1:0]  hold_rem;
  sgs_pkg::sgs_nv_state_t      nv_state;
  logic [sgs_pkg::NV_AW-1:0]   nv_idx;
  logic [31:0]                 rd_word;
  logic                        rd_err;
  logic                        wr_acc;
  logic                        tick;
  logic [CW-1:0]               pulse_pt;
  logic [sgs_pkg::IRQ_W-1:0]   irq_set;
  logic [sgs_pkg::IRQ_W-1:0]   irq_clr;

  sgs_nv_if nv ();

  // The tracking pin is asynchronous, so it passes two flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trk_meta <= 1'b0;
      trk      <= 1'b0;
    end
    else
    begin
      trk_meta <= sat_tracked;
      trk      <= trk_meta;
    end
  end

  // One-second divider; the tick paces the hold-off countdown.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sec_cnt <= '0;
    else if (tick)
      sec_cnt <= '0;
    else
      sec_cnt <= sec_cnt + 1'b1;
  end

  assign tick = (sec_cnt == CW'(TICK_CYCLES - 1));

  // The pulse leaves early by the cable delay; 65535 ns stays in range.
  assign pulse_pt = CW'(TICK_CYCLES - 1)
                    - CW'(cable_delay / sgs_pkg::CLK_PERIOD_NS);

  sgs_holdoff #(.W(sgs_pkg::HOLD_W)) u_holdoff
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick),
    .tracking  (trk),
    .hold      (hold_time),
    .in_sync   (in_sync),
    .remaining (hold_rem)
  );

  sgs_nv_store #(.DEPTH(sgs_pkg::NV_WORDS)) u_store
  (
    .pclk (pclk),
    .nv   (nv)
  );

  // Store port: saves walk the four settings, restores read them back.
  assign nv.we    = (nv_state == sgs_pkg::SGS_NV_SAVE);
  assign nv.addr  = nv_idx;
  assign nv.wdata = (nv_idx == sgs_pkg::NV_IX_CTRL)  ? 32'(ctrl) :
                    (nv_idx == sgs_pkg::NV_IX_HOLD)  ? 32'(hold_time) :
                    (nv_idx == sgs_pkg::NV_IX_DELAY) ? 32'(cable_delay) :
                                                       32'(mask_angle);

  // APB: zero wait states; prdata and pslverr are registered at the end of the setup cycle.
  assign wr_acc = psel & penable & pready & pwrite;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (paddr)
      sgs_pkg::OFF_CTRL:    rd_word = 32'(ctrl);
      sgs_pkg::OFF_HOLD:    rd_word = 32'(hold_time);
      sgs_pkg::OFF_DELAY:   rd_word = 32'(cable_delay);
      sgs_pkg::OFF_MASK:    rd_word = 32'(mask_angle);
      sgs_pkg::OFF_STATUS:
      begin
        rd_word[sgs_pkg::ST_RELAY]   = sync_relay;
        rd_word[sgs_pkg::ST_TRACK]   = trk;
        rd_word[sgs_pkg::ST_OUT_EN]  = time_out_en;
        rd_word[sgs_pkg::ST_NV_BUSY] = (nv_state != sgs_pkg::SGS_NV_IDLE);
        rd_word[sgs_pkg::ST_REM_LSB +: sgs_pkg::HOLD_W] = hold_rem;
      end
      sgs_pkg::OFF_IRQ_ST:  rd_word = 32'(irq_stat);
      sgs_pkg::OFF_IRQ_MSK: rd_word = 32'(irq_mask);
      sgs_pkg::OFF_NV_CMD:  rd_word = 32'h0000_0000;
      default:              rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_word;
    end
  end

  // Settings: a restore load takes priority over a bus write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl        <= '0;
      hold_time   <= sgs_pkg::HOLD_RESET;
      cable_delay <= sgs_pkg::DELAY_RESET;
      mask_angle  <= sgs_pkg::MASK_RESET;
      irq_mask    <= '0;
    end
    else if (nv_state == sgs_pkg::SGS_NV_LOAD)
    begin
      unique case (nv_idx)
        sgs_pkg::NV_IX_CTRL:  ctrl <= nv.rdata[sgs_pkg::CTRL_W-1:0];
        sgs_pkg::NV_IX_HOLD:  hold_time <= HW'(fn_clamp(nv.rdata,
            32'(sgs_pkg::HOLD_MAX)));
        sgs_pkg::NV_IX_DELAY: cable_delay <= nv.rdata[sgs_pkg::DELAY_W-1:0];
        sgs_pkg::NV_IX_MASK:  mask_angle <= MW'(fn_clamp(nv.rdata,
            32'(sgs_pkg::MASK_MAX)));
      endcase
    end
    else if (wr_acc)
    begin
      unique case (paddr)
        sgs_pkg::OFF_CTRL:    ctrl <= pwdata[sgs_pkg::CTRL_W-1:0];
        sgs_pkg::OFF_HOLD:    hold_time <= HW'(fn_clamp(pwdata,
            32'(sgs_pkg::HOLD_MAX)));
        sgs_pkg::OFF_DELAY:   cable_delay <= pwdata[sgs_pkg::DELAY_W-1:0];
        sgs_pkg::OFF_MASK:    mask_angle <= MW'(fn_clamp(pwdata,
            32'(sgs_pkg::MASK_MAX)));
        sgs_pkg::OFF_IRQ_MSK: irq_mask <= pwdata[sgs_pkg::IRQ_W-1:0];
        default:              ;
      endcase
    end
  end

  // Store sequencer; commands arriving while busy are dropped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_state <= sgs_pkg::SGS_NV_IDLE;
      nv_idx   <= '0;
    end
    else
    begin
      unique case (nv_state)
        sgs_pkg::SGS_NV_IDLE:
        begin
          nv_idx <= '0;
          if (wr_acc && paddr == sgs_pkg::OFF_NV_CMD)
          begin
            if (pwdata[sgs_pkg::NV_SAVE])
              nv_state <= sgs_pkg::SGS_NV_SAVE;
            else if (pwdata[sgs_pkg::NV_RESTORE])
              nv_state <= sgs_pkg::SGS_NV_FETCH;
          end
        end
        sgs_pkg::SGS_NV_SAVE:
        begin
          nv_idx <= nv_idx + 1'b1;
          if (nv_idx == sgs_pkg::NV_IX_MASK)
            nv_state <= sgs_pkg::SGS_NV_IDLE;
        end
        sgs_pkg::SGS_NV_FETCH:
          nv_state <= sgs_pkg::SGS_NV_LOAD;
        sgs_pkg::SGS_NV_LOAD:
        begin
          nv_idx <= nv_idx + 1'b1;
          nv_state <= (nv_idx == sgs_pkg::NV_IX_MASK) ?
                      sgs_pkg::SGS_NV_IDLE : sgs_pkg::SGS_NV_FETCH;
        end
      endcase
    end
  end

  // Relay, lamp and output gating; test mode overrides both suppressions.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_relay          <= 1'b0;
      lock_indicator_lamp <= 1'b0;
      time_valid          <= 1'b0;
      time_out_en         <= 1'b0;
      time_pulse          <= 1'b0;
      in_sync_d           <= 1'b0;
    end
    else
    begin
      sync_relay <= in_sync | ctrl[sgs_pkg::CTRL_TEST];
      lock_indicator_lamp <= in_sync | ctrl[sgs_pkg::CTRL_TEST];
      time_valid <= in_sync | ctrl[sgs_pkg::CTRL_TEST]
                    | ctrl[sgs_pkg::CTRL_SUPP_IND];
      time_out_en <= in_sync | ctrl[sgs_pkg::CTRL_TEST]
                     | ctrl[sgs_pkg::CTRL_SUPP_IND]
                     | ~ctrl[sgs_pkg::CTRL_SUPP_OUT];
      time_pulse <= time_out_en & (sec_cnt == pulse_pt);
      in_sync_d  <= in_sync;
    end
  end

  // Elevation mask: low satellites are flagged as not to be used.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sat_use_valid <= 1'b0;
      sat_use       <= 1'b0;
    end
    else
    begin
      sat_use_valid <= sat_in_valid;
      sat_use <= sat_in_valid & (sat_in_elev >= mask_angle);
    end
  end

  // Sticky events; a set in the same cycle as its clear wins.
  assign irq_set[sgs_pkg::IRQ_LOST]   = in_sync_d & ~in_sync;
  assign irq_set[sgs_pkg::IRQ_GAINED] = ~in_sync_d & in_sync;
  assign irq_set[sgs_pkg::IRQ_SATREJ] = sat_in_valid
                                        & (sat_in_elev < mask_angle);
  assign irq_clr = (wr_acc && paddr == sgs_pkg::OFF_IRQ_ST) ?
                   pwdata[sgs_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      irq      <= |(((irq_stat & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lost;
    $fell(in_sync);
  endsequence

  sequence s_track_gone;
    !trk ##1 !trk;
  endsequence

  a_test_relay_on: assert property (
      ctrl[sgs_pkg::CTRL_TEST] [*2] |-> sync_relay && time_valid)
    else $error("Relay or outputs off in test mode.");
  a_lamp_mirror: assert property (
      lock_indicator_lamp == sync_relay)
    else $error("Lamp differs from relay.");
  a_hold_limit: assert property (
      hold_time <= sgs_pkg::HOLD_MAX)
    else $error("Hold-off above its maximum.");
  a_track_restart: assert property (
      trk |=> hold_rem == $past(hold_time))
    else $error("Tracking did not reload the hold-off.");
  a_loss_release: assert property (
      s_lost |-> $past(hold_rem) <= 12'h001 && !$past(trk))
    else $error("Sync lost before the hold-off expired.");
  a_tick_count: assert property (
      s_track_gone ##0 tick && hold_rem > 12'h001
      |=> hold_rem == $past(hold_rem) - 12'h001)
    else $error("Hold-off did not count down on a tick.");
  a_supp_ind: assert property (
      ctrl[sgs_pkg::CTRL_SUPP_IND] |=> time_valid && time_out_en)
    else $error("Outputs not held valid under suppressed indications.");
  a_supp_out: assert property (
      ctrl == 3'h4 && !in_sync |=> !time_out_en ##1 !time_pulse)
    else $error("Outputs not stopped while out of sync.");
  a_mask_reject: assert property (
      sat_in_valid && sat_in_elev < mask_angle |=> sat_use_valid && !sat_use)
    else $error("Satellite below the mask was accepted.");
  a_lost_event: assert property (s_lost |=> irq_stat[sgs_pkg::IRQ_LOST])
    else $error("Loss of sync not recorded.");
endmodule
`default_nettype wire

// ==== sgs_pkg.sv ====
/*
  Package for the satellite sync supervisor: register offsets, field
  positions, reset values, limits and timing constants.
  Assumes a 50 MHz APB clock and byte addresses on the register bus.
*/
`default_nettype none
package sgs_pkg;
  // Clock rate and one-second tick.
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam logic [15:0] CLK_PERIOD_NS = 16'h0014;
  localparam int unsigned SEC_NS        = 1_000_000_000;
  localparam int unsigned TICK_CYCLES   = SEC_NS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_HOLD    = 8'h04;
  localparam logic [7:0] OFF_DELAY   = 8'h08;
  localparam logic [7:0] OFF_MASK    = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h14;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h18;
  localparam logic [7:0] OFF_NV_CMD  = 8'h1C;

  // Control bits.
  localparam int CTRL_TEST     = 0;
  localparam int CTRL_SUPP_IND = 1;
  localparam int CTRL_SUPP_OUT = 2;
  localparam int CTRL_W        = 3;

  // Status bits and fields.
  localparam int ST_RELAY    = 0;
  localparam int ST_TRACK    = 1;
  localparam int ST_OUT_EN   = 2;
  localparam int ST_NV_BUSY  = 3;
  localparam int ST_REM_LSB  = 16;

  // Interrupt event bits.
  localparam int IRQ_LOST   = 0;
  localparam int IRQ_GAINED = 1;
  localparam int IRQ_SATREJ = 2;
  localparam int IRQ_W      = 3;

  // Parameter store commands.
  localparam int NV_SAVE    = 0;
  localparam int NV_RESTORE = 1;

  // Hold-off time in seconds, mask angle in degrees.
  localparam int          HOLD_W       = 12;
  localparam logic [11:0] HOLD_RESET   = 12'h03C;
  localparam logic [11:0] HOLD_MAX     = 12'h9F6;
  localparam int          MASK_W       = 7;
  localparam logic [6:0]  MASK_RESET   = 7'h05;
  localparam logic [6:0]  MASK_MAX     = 7'h5A;
  localparam int          DELAY_W      = 16;
  localparam logic [15:0] DELAY_RESET  = 16'h0000;

  // Parameter store geometry: control, hold, delay, mask.
  localparam int          NV_WORDS     = 4;
  localparam int          NV_AW        = 2;
  localparam logic [1:0]  NV_IX_CTRL   = 2'h0;
  localparam logic [1:0]  NV_IX_HOLD   = 2'h1;
  localparam logic [1:0]  NV_IX_DELAY  = 2'h2;
  localparam logic [1:0]  NV_IX_MASK   = 2'h3;

  typedef enum logic [1:0] {SGS_NV_IDLE, SGS_NV_SAVE, SGS_NV_FETCH,
                            SGS_NV_LOAD} sgs_nv_state_t;
endpackage
`default_nettype wire

// ==== sgs_nv_if.sv ====
/*
  Interface between the supervisor and its parameter store.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface sgs_nv_if;
  logic                     we;
  logic [sgs_pkg::NV_AW-1:0] addr;
  logic [31:0]              wdata;
  logic [31:0]              rdata;

  modport host (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== sgs_nv_store.sv ====
/*
  Parameter store: a small word memory with registered read data.
  Assumes the host drives address and write enable from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_nv_store
#(
  parameter int DEPTH = sgs_pkg::NV_WORDS
)
(
  input  wire logic pclk,
  sgs_nv_if.mem     nv
);
  logic [31:0] mem [DEPTH];

  initial
  begin
    if (DEPTH != (1 << sgs_pkg::NV_AW))
      $error("sgs_nv_store: DEPTH must match the address width.");
  end

  // The array has no reset, so saved settings outlive a bus reset.
  always_ff @(posedge pclk)
  begin
    if (nv.we)
      mem[nv.addr] <= nv.wdata;
    nv.rdata <= mem[nv.addr];
  end
endmodule
`default_nettype wire

// ==== sgs_holdoff.sv ====
/*
  Hold-off timer: keeps sync asserted for a set number of one-second
  ticks after the last satellite is lost.
  Assumes tick is a one-cycle pulse and tracking is already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_holdoff
#(
  parameter int W = sgs_pkg::HOLD_W
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         tick,
  input  wire logic         tracking,
  input  wire logic [W-1:0] hold,
  output var  logic         in_sync,
  output var  logic [W-1:0] remaining
);
  // The counter must reach the largest hold-off that software may set.
  initial
  begin
    if ((2 ** W) - 1 < int'(sgs_pkg::HOLD_MAX))
      $error("sgs_holdoff: W too narrow for the largest hold-off.");
  end

  // Tracking reloads the full count; absence counts down one per tick.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_sync   <= 1'b0;
      remaining <= '0;
    end
    else if (tracking)
    begin
      in_sync   <= 1'b1;
      remaining <= hold;
    end
    else if (remaining == '0)
      in_sync <= 1'b0;
    else if (tick)
    begin
      remaining <= remaining - 1'b1;
      if (remaining == W'(1))
        in_sync <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== sgs_rx_model.sv ====
/*
  Receiver model: drives the tracking pin and the satellite reports.
  Assumes the bench commands it from the supervisor's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sgs_rx_model
#(
  parameter int LAG = 1
)
(
  input  wire logic       pclk,
  input  wire logic       lock_req,
  input  wire logic       rep_go,
  input  wire logic [6:0] rep_elev,
  output var  logic       sat_tracked,
  output var  logic       sat_in_valid,
  output var  logic [6:0] sat_in_elev
);
  logic [7:0] lag_sr = 8'h00;

  // Lock shows LAG cycles after the request, so slow acquisition can be set.
  always_ff @(posedge pclk)
  begin
    lag_sr <= {lag_sr[6:0], lock_req};
  end
  assign sat_tracked = lag_sr[LAG-1];

  // Reports last one cycle; in between the bus carries junk, not old data.
  always_ff @(posedge pclk)
  begin
    sat_in_valid <= rep_go;
    sat_in_elev  <= rep_go ? rep_elev : ~rep_elev;
  end
endmodule
`default_nettype wire

// ==== gps_sync_status_supervisor_tb_top.sv ====
/*
  Self-checking bench for the sync supervisor: registers, hold-off,
  modes, mask angle, cable delay and the parameter store.
  Assumes a shortened second of 4096 cycles at 50 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module gps_sync_status_supervisor_tb_top;
  localparam int T = 4096;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, lock_req = 1'b0, rep_go = 1'b0, e;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, sat_tracked, sat_in_valid, sat_use, irq;
  logic        sat_use_valid, sync_relay, lock_indicator_lamp, time_valid;
  logic        time_out_en, time_pulse;
  logic [3:0]  outs, xo;
  logic [6:0]  sat_in_elev, rep_elev = 7'h00, m, el;
  int          fail_count = 0, num_checks = 0, cyc = 0, n, k, p0, ph;
  logic [39:0] rst_tab [6] = '{{sgs_pkg::OFF_CTRL, 32'h0},
    {sgs_pkg::OFF_HOLD, 32'h3C}, {sgs_pkg::OFF_DELAY, 32'h0},
    {sgs_pkg::OFF_MASK, 32'h5}, {sgs_pkg::OFF_IRQ_ST, 32'h0},
    {sgs_pkg::OFF_IRQ_MSK, 32'h0}};
  int          dly [3] = '{60, 120, 240};

  // Free clock and a cycle stamp for pulse phases.
  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // Relay, lamp, valid and enable gathered for the mode checks.
  assign outs = {sync_relay, lock_indicator_lamp, time_valid, time_out_en};

  sgs_supervisor #(.TICK_CYCLES(T)) i_sgs_supervisor (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sat_tracked(sat_tracked),
    .sat_in_valid(sat_in_valid), .sat_in_elev(sat_in_elev),
    .sat_use_valid(sat_use_valid), .sat_use(sat_use),
    .sync_relay(sync_relay), .lock_indicator_lamp(lock_indicator_lamp),
    .time_valid(time_valid), .time_out_en(time_out_en),
    .time_pulse(time_pulse), .irq(irq));

  sgs_rx_model i_sgs_rx_model (.pclk(pclk), .lock_req(lock_req),
    .rep_go(rep_go), .rep_elev(rep_elev), .sat_tracked(sat_tracked),
    .sat_in_valid(sat_in_valid), .sat_in_elev(sat_in_elev));

  // One APB transfer; the request holds until pready is seen high, for at most 16 cycles.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 16);
    `CHK("pready", 1'b1, pready)
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wcyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // Bounded wait for the relay to reach a level; n holds cycles spent.
  task automatic wait_relay(input logic lv, input int lim);
    n = 0;
    while (sync_relay !== lv && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic report(input logic [6:0] v);
    @(posedge pclk);
    rep_go <= 1'b1;
    rep_elev <= v;
    @(posedge pclk);
    rep_go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (sat_use_valid !== 1'b1 && n < 8);
  endtask

  task automatic pulse_phase();
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (time_pulse !== 1'b1 && n < 2 * T);
    ph = cyc % T;
  endtask

  // A few cycles pass first, so a pulse launched under the old mode is missed.
  task automatic count_pulses();
    repeat (3) @(posedge pclk);
    k = 0;
    repeat (T)
    begin
      @(posedge pclk);
      if (time_pulse === 1'b1)
        k++;
    end
  endtask

  // Polls the store's busy flag with a bounded number of reads.
  task automatic nv_wait();
    int t;
    t = 0;
    do
    begin
      rd(sgs_pkg::OFF_STATUS);
      t++;
    end
    while (r[sgs_pkg::ST_NV_BUSY] !== 1'b0 && t < 20);
  endtask

  // Expected relay, lamp, valid and enable while out of sync.
  function automatic logic [3:0] exp_out(input logic [2:0] c);
    logic tm;
    logic si;
    tm = c[sgs_pkg::CTRL_TEST];
    si = c[sgs_pkg::CTRL_SUPP_IND];
    exp_out = {tm, tm, tm | si, tm | si | ~c[sgs_pkg::CTRL_SUPP_OUT]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    void'($urandom(64154));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_tab[i])
    begin
      rd(rst_tab[i][39:32]);
      `CHK("reset value", rst_tab[i][31:0], r)
    end
    rd(8'h20);
    `CHK("unmapped", 33'h1_0000_0000, {e, r})
    wr(sgs_pkg::OFF_HOLD, 32'hFFF);
    rd(sgs_pkg::OFF_HOLD);
    `CHK("hold clamp", 32'h9F6, r)
    wr(sgs_pkg::OFF_MASK, 32'h7F);
    rd(sgs_pkg::OFF_MASK);
    `CHK("mask clamp", 32'h5A, r)
    m = 7'(1 + $urandom_range(89));
    wr(sgs_pkg::OFF_MASK, {25'h0, m});
    for (int i = 0; i < 10; i++)
    begin
      el = (i == 0) ? m - 7'h01 : (i == 1) ? m : 7'($urandom_range(90));
      report(el);
      `CHK("sat_use_valid", 1'b1, sat_use_valid)
      `CHK("sat_use", el >= m, sat_use)
    end
    rd(sgs_pkg::OFF_IRQ_ST);
    `CHK("reject event", 1'b1, r[sgs_pkg::IRQ_SATREJ])
    // Three seconds of hold-off: loss comes two to three seconds after.
    wr(sgs_pkg::OFF_HOLD, 32'h3);
    wr(sgs_pkg::OFF_IRQ_MSK, 32'h1);
    lock_req <= 1'b1;
    wait_relay(1'b1, 20);
    `CHK("locked", 4'hF, outs)
    rd(sgs_pkg::OFF_STATUS);
    `CHK("remaining", 12'h003, r[27:16])
    `CHK("masked irq", 1'b0, irq)
    wr(sgs_pkg::OFF_IRQ_ST, 32'h7);
    // Short blackout, brief relock, then a full loss from the restart.
    lock_req <= 1'b0;
    wcyc(T + T / 2);
    `CHK("relay held", 1'b1, sync_relay)
    lock_req <= 1'b1;
    wcyc(10);
    lock_req <= 1'b0;
    wait_relay(1'b0, 4 * T);
    `CHK("hold span", 1'b1, n >= 2*T && n <= 3*T+16)
    wcyc(3);
    `CHK("irq lost", 1'b1, irq)
    wr(sgs_pkg::OFF_IRQ_ST, 32'h1);
    wcyc(3);
    `CHK("irq cleared", 1'b0, irq)
    for (int c = 0; c < 8; c++)
    begin
      wr(sgs_pkg::OFF_CTRL, 32'(c));
      wcyc(3);
      xo = exp_out(c[2:0]);
      `CHK("mode relay", xo[3:2], outs[3:2])
      `CHK("mode outs", xo[1:0], outs[1:0])
    end
    wr(sgs_pkg::OFF_CTRL, 32'h4);
    count_pulses();
    `CHK("pulses stopped", 0, k)
    wr(sgs_pkg::OFF_CTRL, 32'h6);
    count_pulses();
    `CHK("pulses kept", 1, k)
    wr(sgs_pkg::OFF_CTRL, 32'h0);
    lock_req <= 1'b1;
    wait_relay(1'b1, 20);
    pulse_phase();
    p0 = ph;
    foreach (dly[i])
    begin
      wr(sgs_pkg::OFF_DELAY, 32'(dly[i]));
      pulse_phase();
      pulse_phase();
      `CHK("pulse phase", (p0 + T - dly[i] / 20) % T, ph)
    end
    wr(sgs_pkg::OFF_HOLD, 32'h7);
    wr(sgs_pkg::OFF_NV_CMD, 32'h1);
    nv_wait();
    wr(sgs_pkg::OFF_HOLD, 32'h3C);
    wr(sgs_pkg::OFF_DELAY, 32'h0);
    wr(sgs_pkg::OFF_NV_CMD, 32'h2);
    nv_wait();
    rd(sgs_pkg::OFF_HOLD);
    `CHK("restored hold", 32'h7, r)
    rd(sgs_pkg::OFF_DELAY);
    `CHK("restored delay", 32'hF0, r)
    // A mid-run reset brings back the defaults; the store keeps its words.
    presetn <= 1'b0;
    wcyc(3);
    presetn <= 1'b1;
    rd(sgs_pkg::OFF_HOLD);
    `CHK("hold after reset", 32'h3C, r)
    wr(sgs_pkg::OFF_NV_CMD, 32'h2);
    nv_wait();
    rd(sgs_pkg::OFF_HOLD);
    `CHK("hold kept", 32'h7, r)
    wrap_up();
  end

  // Watchdog sized well above the expected run of about 53000 cycles.
  initial
  begin
    #(20 * 90000);
    fail_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
